//--- bench/svo_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module svo_host_model #(
  parameter int DELAY = 3
) (
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // Host intent and the interlock outputs it watches.
  input  wire logic       wantData,
  input  wire logic [2:0] circuitOutN,
  output var  logic       absDataRequest,
  output var  logic       readySeen
);
  int cnt;

  // The host raises the data request some cycles after it decides to, never at once.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt            <= 0;
      absDataRequest <= 1'b0;
    end else if (!wantData) begin
      cnt            <= 0;
      absDataRequest <= 1'b0;
    end else if (cnt < DELAY) begin
      cnt <= cnt + 1;
    end else begin
      absDataRequest <= 1'b1;
    end
  end

  // Default routing puts the ready signal on the third circuit, active low.
  assign readySeen = ~circuitOutN[2];
endmodule
`default_nettype wire

//--- bench/svo_status_out_tb.sv
`timescale 1ns/1ps
`default_nettype none
module svo_status_out_tb;
  import svo_pkg::*;
  logic        core_clk, rstn, ce, psel, penable, pwrite, controlTick, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  svo_mode_t   controlMode;
  logic [15:0] motorSpeed, posError;
  logic        positioningDoneIn, speedMatchIn, alarmActive, mainPowerOn, overloadWarn;
  logic        regenWarn, absEncoderFitted, absDataSent, absDataRequest, wantData, readySeen;
  logic [2:0]  alarmCode, circuitOutN;
  logic        codeBitFirstN, codeBitSecondN, codeBitThirdN, statusDisplayRun;
  logic        speedMonitorRun, irq;
  int          n_errors, total_checks;

  svo_status_out uut (
    .core_clk, .rstn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .controlTick, .controlMode, .motorSpeed, .posError, .positioningDoneIn,
    .speedMatchIn, .alarmActive, .alarmCode, .mainPowerOn, .overloadWarn, .regenWarn,
    .absEncoderFitted, .absDataSent, .absDataRequest, .circuitOutN, .codeBitFirstN,
    .codeBitSecondN, .codeBitThirdN, .statusDisplayRun, .speedMonitorRun, .irq
  );

  svo_host_model #(.DELAY(4)) host (
    .core_clk, .rstn, .wantData, .circuitOutN, .absDataRequest, .readySeen
  );

  always #10 core_clk = ~core_clk;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic circ(input logic [2:0] e);
    chk("circuits", {29'h0, e}, {29'h0, circuitOutN});
  endtask

  task automatic codes(input logic [2:0] e);
    chk("codes", {29'h0, e}, {29'h0, codeBitThirdN, codeBitSecondN, codeBitFirstN});
  endtask

  task automatic done(input string n);
    $display("test %s finished, mismatches so far %0d", n, n_errors);
  endtask

  // One APB transfer; the request is held until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    int k;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1);
    chk("access cycles", 32'h1, 32'(k));
    r = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e, input logic ee);
    logic [31:0] r;
    logic        err;
    apb(1'b0, a, 32'h0, r, err);
    chk(n, e, r);
    chk({n, " error"}, {31'h0, ee}, {31'h0, err});
  endtask

  // Inputs change at one edge, the tick is sampled at the next, pin results land one later.
  task automatic tick(input logic [15:0] spd, input logic [15:0] err);
    @(posedge core_clk);
    motorSpeed  <= spd;
    posError    <= err;
    controlTick <= 1'b1;
    @(posedge core_clk);
    controlTick <= 1'b0;
    cyc(3);
  endtask

  initial begin
    cyc(20000);
    n_errors++;
    report_and_stop();
  end

  initial begin
    logic [2:0] exp;
    core_clk = 1'b0; rstn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; controlTick = 1'b0; controlMode = MODE_SPEED;
    motorSpeed = 16'h0000; posError = 16'h0064; positioningDoneIn = 1'b0;
    speedMatchIn = 1'b0; alarmActive = 1'b0; alarmCode = 3'h0; mainPowerOn = 1'b0;
    overloadWarn = 1'b0; regenWarn = 1'b0; absEncoderFitted = 1'b0; absDataSent = 1'b0;
    wantData = 1'b0; n_errors = 0; total_checks = 0;
    cyc(10);
    rstn <= 1'b1;
    cyc(1);
    circ(3'b111);
    codes(3'b111);
    rd("rotation level", ADDR_ROT_LEVEL, 32'h14, 1'b0);
    rd("select first", ADDR_OUT_SEL1, 32'h3211, 1'b0);
    rd("select second", ADDR_OUT_SEL2, 32'h0, 1'b0);
    rd("select third", ADDR_OUT_SEL3, 32'h0, 1'b0);
    rd("near width", ADDR_NEAR_WIDTH, 32'h7, 1'b0);
    rd("code select", ADDR_CODE_SEL, 32'h0, 1'b0);
    rd("irq enable", ADDR_IRQ_ENABLE, 32'h0, 1'b0);
    rd("unmapped", 8'h3c, 32'h0, 1'b1);
    done("reset");
    tick(16'd20, 16'd0);
    circ(3'b111);
    tick(16'd21, 16'd0);
    circ(3'b101);
    chk("display", 32'h3, {30'h0, statusDisplayRun, speedMonitorRun});
    wr(ADDR_ROT_LEVEL, 32'h0);
    rd("rotation level", ADDR_ROT_LEVEL, 32'h14, 1'b0);
    wr(ADDR_ROT_LEVEL, 32'h2711);
    rd("rotation level", ADDR_ROT_LEVEL, 32'h14, 1'b0);
    wr(ADDR_ROT_LEVEL, 32'h2710);
    rd("rotation level", ADDR_ROT_LEVEL, 32'h2710, 1'b0);
    tick(16'd10000, 16'd0);
    circ(3'b111);
    chk("display", 32'h0, {30'h0, statusDisplayRun, speedMonitorRun});
    tick(16'd10001, 16'd0);
    circ(3'b101);
    controlMode <= MODE_TORQUE;
    tick(16'd10001, 16'd0);
    circ(3'b100);
    controlMode <= MODE_SPEED;
    tick(16'd0, 16'd0);
    wr(ADDR_ROT_LEVEL, 32'h14);
    done("running");
    mainPowerOn <= 1'b1;
    cyc(3);
    chk("ready", 32'h1, {31'h0, readySeen});
    alarmActive <= 1'b1;
    cyc(3);
    chk("ready", 32'h0, {31'h0, readySeen});
    alarmActive <= 1'b0;
    absEncoderFitted <= 1'b1;
    cyc(3);
    chk("ready", 32'h0, {31'h0, readySeen});
    wantData <= 1'b1;
    cyc(12);
    chk("ready", 32'h0, {31'h0, readySeen});
    absDataSent <= 1'b1;
    cyc(3);
    chk("ready", 32'h1, {31'h0, readySeen});
    wantData <= 1'b0;
    cyc(8);
    chk("ready", 32'h0, {31'h0, readySeen});
    absEncoderFitted <= 1'b0;
    absDataSent <= 1'b0;
    cyc(3);
    circ(3'b011);
    done("ready");
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_OUT_SEL2, 32'(r) << SEL2_WARN_LSB);
      for (int k = 0; k < 2; k++) begin
        exp = 3'b011;
        if (r != 0) exp[r-1] = 1'b0;
        overloadWarn <= (k == 0);
        regenWarn <= (k == 1);
        cyc(3);
        circ(exp);
        overloadWarn <= 1'b0;
        regenWarn <= 1'b0;
        cyc(3);
        circ(3'b011);
      end
    end
    wr(ADDR_OUT_SEL2, 32'h2000);
    tick(16'd21, 16'd0);
    circ(3'b001);
    overloadWarn <= 1'b1;
    tick(16'd0, 16'd0);
    circ(3'b001);
    overloadWarn <= 1'b0;
    cyc(3);
    circ(3'b011);
    wr(ADDR_OUT_SEL2, 32'h0);
    done("warning");
    overloadWarn <= 1'b1;
    cyc(3);
    codes(3'b111);
    wr(ADDR_CODE_SEL, 32'h1);
    cyc(3);
    codes(3'b110);
    overloadWarn <= 1'b0;
    regenWarn <= 1'b1;
    cyc(3);
    codes(3'b101);
    alarmActive <= 1'b1;
    alarmCode <= 3'b100;
    cyc(3);
    codes(3'b011);
    wr(ADDR_CODE_SEL, 32'h0);
    alarmCode <= 3'b010;
    cyc(3);
    codes(3'b101);
    alarmActive <= 1'b0;
    alarmCode <= 3'b000;
    regenWarn <= 1'b0;
    cyc(3);
    codes(3'b111);
    done("codes");
    controlMode <= MODE_POSITION;
    wr(ADDR_OUT_SEL3, 32'h1);
    wr(ADDR_NEAR_WIDTH, 32'hfb);
    rd("near width", ADDR_NEAR_WIDTH, 32'h7, 1'b0);
    wr(ADDR_NEAR_WIDTH, 32'h0);
    rd("near width", ADDR_NEAR_WIDTH, 32'h7, 1'b0);
    tick(16'd0, 16'd6);
    circ(3'b010);
    tick(16'd0, 16'd7);
    circ(3'b011);
    wr(ADDR_NEAR_WIDTH, 32'hfa);
    rd("near width", ADDR_NEAR_WIDTH, 32'hfa, 1'b0);
    tick(16'd0, 16'd249);
    circ(3'b010);
    tick(16'd0, 16'd250);
    circ(3'b011);
    wr(ADDR_OUT_SEL3, 32'h0);
    tick(16'd0, 16'd0);
    circ(3'b011);
    positioningDoneIn <= 1'b1;
    cyc(3);
    circ(3'b010);
    positioningDoneIn <= 1'b0;
    wr(ADDR_OUT_SEL3, 32'h1);
    controlMode <= MODE_SPEED;
    tick(16'd0, 16'd0);
    circ(3'b011);
    wr(ADDR_OUT_SEL3, 32'h0);
    wr(ADDR_NEAR_WIDTH, 32'h7);
    done("near");
    wr(ADDR_IRQ_CLEAR, 32'hf);
    cyc(2);
    rd("irq status", ADDR_IRQ_STAT, 32'h0, 1'b0);
    wr(ADDR_IRQ_ENABLE, 32'h1);
    tick(16'd21, 16'd0);
    chk("irq", 32'h1, {31'h0, irq});
    rd("irq status", ADDR_IRQ_STAT, 32'h1, 1'b0);
    wr(ADDR_IRQ_CLEAR, 32'h1);
    cyc(2);
    chk("irq", 32'h0, {31'h0, irq});
    wr(ADDR_IRQ_ENABLE, 32'h0);
    tick(16'd0, 16'd0);
    tick(16'd21, 16'd0);
    chk("irq", 32'h0, {31'h0, irq});
    rd("irq status", ADDR_IRQ_STAT, 32'h1, 1'b0);
    rd("status", ADDR_STATUS, 32'h63, 1'b0);
    ce <= 1'b0;
    tick(16'd0, 16'd0);
    circ(3'b001);
    ce <= 1'b1;
    done("interrupt");
    report_and_stop();
  end
endmodule
`default_nettype wire

//--- design/svo_route.sv
`timescale 1ns/1ps
`default_nettype none
module svo_route #(
  parameter int NSIG = 5,
  parameter int NCIR = 3
) (
  // Active-high status signals and their routing fields.
  input  wire logic [NSIG-1:0]      sigOn,
  input  wire logic [NSIG-1:0][3:0] route,
  // Active-high state of each output circuit.
  output var  logic [NCIR-1:0]      circuitOn
);
  import svo_pkg::*;

  // A field value of 0 or above the circuit count routes nowhere.
  for (genvar c = 0; c < NCIR; c++) begin : g_circ
    logic [NSIG-1:0] hit;
    for (genvar s = 0; s < NSIG; s++) begin : g_sig
      assign hit[s] = routeHit(route[s], c + 1);
    end
    assign circuitOn[c] = |(sigOn & hit); // R9
  end

endmodule
`default_nettype wire

//--- design/svo_status_out.sv
// Function
// R1 - Running output low while motor speed exceeds the rotation level, any mode.
// R2 - Rotation level setting 1 to 10000 rpm, reset value 20.
// R3 - Running is also shown on status display and speed monitor view.
// R4 - First output selection resets to 3211, running routed to circuit two.
// R5 - Ready only with no alarm and main circuit power on.
// R6 - With absolute encoder, ready also needs data request high and data sent.
// R7 - Warning active low during overload or regenerative overload warning.
// R8 - Warning route field: 0 none, 1 to 3 picks circuit; reset 0000.
// R9 - Signals sharing one output circuit are ORed.
// R10 - Code select 0 gives alarm codes only; 1 adds warnings, alarm first.
// R11 - Overload drives first code bit low, regen overload the second; with both active the code drives only the first bit low.
// R12 - In position control, near active while position error below near width.
// R13 - Near output unrouted until its field picks a circuit; reset 0000.
// R14 - Near width setting 1 to 250 reference units, reset value 7.
// R15 - Software should set near width above positioning completed width.
// R16 - Comparisons run once per control cycle; outputs come from registers.
`timescale 1ns/1ps
`default_nettype none
module svo_status_out (
  // Clock, reset and clock enable.
  input  wire logic                   core_clk,
  input  wire logic                   rstn,
  input  wire logic                   ce,
  // APB slave.
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output var  logic [31:0]            prdata,
  output var  logic                   pready,
  output var  logic                   pslverr,
  // Control core status.
  input  wire logic                   controlTick,
  input  wire svo_pkg::svo_mode_t     controlMode,
  input  wire logic [15:0]            motorSpeed,
  input  wire logic [15:0]            posError,
  input  wire logic                   positioningDoneIn,
  input  wire logic                   speedMatchIn,
  input  wire logic                   alarmActive,
  input  wire logic [2:0]             alarmCode,
  input  wire logic                   mainPowerOn,
  input  wire logic                   overloadWarn,
  input  wire logic                   regenWarn,
  input  wire logic                   absEncoderFitted,
  input  wire logic                   absDataSent,
  // Pin from the host.
  input  wire logic                   absDataRequest,
  // Sequence outputs, active low.
  output var  logic [2:0]             circuitOutN,
  output var  logic                   codeBitFirstN,
  output var  logic                   codeBitSecondN,
  output var  logic                   codeBitThirdN,
  // Display indications and interrupt.
  output var  logic                   statusDisplayRun,
  output var  logic                   speedMonitorRun,
  output var  logic                   irq
);
  import svo_pkg::*;

  // Settings.
  logic [13:0]       rotLevel_q;
  logic [15:0]       outSel1_q;
  logic [15:0]       outSel2_q;
  logic [15:0]       outSel3_q;
  logic [7:0]        nearWidth_q;
  logic              codeSel_q;
  logic [IRQ_W-1:0]  irqStat_q;
  logic [IRQ_W-1:0]  irqEn_q;

  // Status levels.
  logic              runningOn_q;
  logic              readyOn_q;
  logic              warnOn_q;
  logic              nearOn_q;
  logic              absReqSync;

  // Bus decode.
  wire logic         setupPhase = psel && !penable;
  wire logic         wrCommit   = psel && penable && pready && pwrite;
  wire logic         addrHit    = (paddr == ADDR_ROT_LEVEL) || (paddr == ADDR_OUT_SEL1) ||
                                  (paddr == ADDR_OUT_SEL2) || (paddr == ADDR_OUT_SEL3) ||
                                  (paddr == ADDR_NEAR_WIDTH) || (paddr == ADDR_CODE_SEL) ||
                                  (paddr == ADDR_STATUS) || (paddr == ADDR_IRQ_STAT) ||
                                  (paddr == ADDR_IRQ_CLEAR) || (paddr == ADDR_IRQ_ENABLE);
  wire logic         wrRot      = wrCommit && (paddr == ADDR_ROT_LEVEL);
  wire logic         wrSel1     = wrCommit && (paddr == ADDR_OUT_SEL1);
  wire logic         wrSel2     = wrCommit && (paddr == ADDR_OUT_SEL2);
  wire logic         wrSel3     = wrCommit && (paddr == ADDR_OUT_SEL3);
  wire logic         wrNear     = wrCommit && (paddr == ADDR_NEAR_WIDTH);
  wire logic         wrCode     = wrCommit && (paddr == ADDR_CODE_SEL);
  wire logic         wrClear    = wrCommit && (paddr == ADDR_IRQ_CLEAR);
  wire logic         wrEnable   = wrCommit && (paddr == ADDR_IRQ_ENABLE);

  // Out-of-range setting writes are ignored and the old value stays.
  wire logic         rotValid   = (pwdata[31:14] == 18'h00000) &&
                                  (pwdata[13:0] >= ROT_LEVEL_MIN) &&
                                  (pwdata[13:0] <= ROT_LEVEL_MAX);
  wire logic         nearValid  = (pwdata[31:8] == 24'h000000) &&
                                  (pwdata[7:0] >= NEAR_WIDTH_MIN) &&
                                  (pwdata[7:0] <= NEAR_WIDTH_MAX);

  // Comparators, sampled only on the control tick.
  wire logic         speedAbove = motorSpeed > {2'h0, rotLevel_q};
  wire logic         errInside  = posError < {8'h00, nearWidth_q};
  wire logic         posMode    = (controlMode == MODE_POSITION);
  wire logic         runningOn_d = controlTick ? speedAbove : runningOn_q;
  wire logic         nearOn_d    = controlTick ? (posMode && errInside) : nearOn_q;

  // Ready and warning conditions.
  wire logic         absReady   = !absEncoderFitted || (absReqSync && absDataSent);
  wire logic         readyOn_d  = !alarmActive && mainPowerOn && absReady;
  wire logic         warnOn_d   = overloadWarn || regenWarn;

  // Mode-dependent coincidence signals sharing the first routing fields.
  wire logic         posDoneEff  = (controlMode == MODE_TORQUE) ||
                                   (posMode && positioningDoneIn);
  wire logic         spdMatchEff = (controlMode == MODE_TORQUE) ||
                                   ((controlMode == MODE_SPEED) && speedMatchIn);

  // Routing of status levels onto output circuits.
  logic [NUM_ROUTED-1:0]      routeSig;
  logic [NUM_ROUTED-1:0][3:0] routeSel;
  logic [NUM_CIRCUITS-1:0]    circuitOn;

  assign routeSig = {nearOn_q, warnOn_q, readyOn_q, runningOn_q,
                     posDoneEff | spdMatchEff};
  assign routeSel[0] = (controlMode == MODE_SPEED) ?
                       outSel1_q[SEL1_SPDMATCH_LSB +: ROUTE_W] :
                       outSel1_q[SEL1_POSDONE_LSB +: ROUTE_W];
  assign routeSel[1] = outSel1_q[SEL1_RUNNING_LSB +: ROUTE_W]; // R4
  assign routeSel[2] = outSel1_q[SEL1_READY_LSB +: ROUTE_W];
  assign routeSel[3] = outSel2_q[SEL2_WARN_LSB +: ROUTE_W]; // R8
  assign routeSel[4] = outSel3_q[SEL3_NEAR_LSB +: ROUTE_W]; // R13

  // Warning code outputs, active high before the output inversion.
  wire logic [2:0]   warnCode   = overloadWarn ? 3'h1 : (regenWarn ? 3'h2 : 3'h0); // R11
  wire logic [2:0]   codeOn     = alarmActive ? alarmCode :
                                  (codeSel_q ? warnCode : 3'h0); // R10

  // Interrupt events: running and near rising, ready falling, warning rising.
  wire logic [IRQ_W-1:0] irqEvent = {nearOn_d & ~nearOn_q,
                                     warnOn_d & ~warnOn_q,
                                     ~readyOn_d & readyOn_q,
                                     runningOn_d & ~runningOn_q};
  wire logic [IRQ_W-1:0] irqClr   = wrClear ? pwdata[IRQ_W-1:0] : '0;
  wire logic [IRQ_W-1:0] irqStat_d = irqEvent | (irqStat_q & ~irqClr);

  wire logic [31:0]  statusWord = {25'h0000000, ~circuitOutN,
                                   nearOn_q, warnOn_q, readyOn_q, runningOn_q};
  logic [31:0]       readData;

  always_comb begin
    readData = 32'h00000000;
    unique case (paddr)
      ADDR_ROT_LEVEL:  readData = {18'h00000, rotLevel_q};
      ADDR_OUT_SEL1:   readData = {16'h0000, outSel1_q};
      ADDR_OUT_SEL2:   readData = {16'h0000, outSel2_q};
      ADDR_OUT_SEL3:   readData = {16'h0000, outSel3_q};
      ADDR_NEAR_WIDTH: readData = {24'h000000, nearWidth_q};
      ADDR_CODE_SEL:   readData = {31'h00000000, codeSel_q};
      ADDR_STATUS:     readData = statusWord;
      ADDR_IRQ_STAT:   readData = {28'h0000000, irqStat_q};
      ADDR_IRQ_ENABLE: readData = {28'h0000000, irqEn_q};
      default:         readData = 32'h00000000;
    endcase
  end

  svo_sync #(
    .W (1)
  ) u_absReqSync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .ce       (ce),
    .asyncIn  (absDataRequest),
    .syncOut  (absReqSync)
  );

  svo_route #(
    .NSIG (NUM_ROUTED),
    .NCIR (NUM_CIRCUITS)
  ) u_route (
    .sigOn     (routeSig),
    .route     (routeSel),
    .circuitOn (circuitOn)
  );

  // Bus answer: data is captured in the setup cycle, pready rises for the access.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= setupPhase;
      if (setupPhase) begin
        prdata  <= pwrite ? 32'h00000000 : readData;
        pslverr <= !addrHit;
      end
    end
  end

  // Settings written by software.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rotLevel_q  <= ROT_LEVEL_RST;
      outSel1_q   <= OUT_SEL1_RST;
      outSel2_q   <= OUT_SEL2_RST;
      outSel3_q   <= OUT_SEL3_RST;
      nearWidth_q <= NEAR_WIDTH_RST;
      codeSel_q   <= CODE_SEL_RST;
      irqEn_q     <= '0;
    end else if (ce) begin
      if (wrRot && rotValid) rotLevel_q <= pwdata[13:0]; // R2
      if (wrSel1) outSel1_q <= pwdata[15:0];
      if (wrSel2) outSel2_q <= pwdata[15:0];
      if (wrSel3) outSel3_q <= pwdata[15:0];
      if (wrNear && nearValid) nearWidth_q <= pwdata[7:0]; // R14
      if (wrCode) codeSel_q <= pwdata[0];
      if (wrEnable) irqEn_q <= pwdata[IRQ_W-1:0];
    end
  end

  // Status levels.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      runningOn_q <= 1'b0;
      nearOn_q    <= 1'b0;
      readyOn_q   <= 1'b0;
      warnOn_q    <= 1'b0;
    end else if (ce) begin
      runningOn_q <= runningOn_d; // R1 R16
      nearOn_q    <= nearOn_d; // R12 R16
      readyOn_q   <= readyOn_d; // R5 R6
      warnOn_q    <= warnOn_d; // R7
    end
  end

  // Registered pin and display outputs.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      circuitOutN      <= 3'h7;
      codeBitFirstN    <= 1'b1;
      codeBitSecondN   <= 1'b1;
      codeBitThirdN    <= 1'b1;
      statusDisplayRun <= 1'b0;
      speedMonitorRun  <= 1'b0;
    end else if (ce) begin
      circuitOutN      <= ~circuitOn; // R9 R16
      codeBitFirstN    <= ~codeOn[0];
      codeBitSecondN   <= ~codeOn[1];
      codeBitThirdN    <= ~codeOn[2];
      statusDisplayRun <= runningOn_q; // R3
      speedMonitorRun  <= runningOn_q; // R3
    end
  end

  // Interrupt status: a new event wins over a clear in the same cycle.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irqStat_q <= '0;
      irq       <= 1'b0;
    end else if (ce) begin
      irqStat_q <= irqStat_d;
      irq       <= |(irqStat_d & irqEn_q);
    end
  end

  // Checks.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence sTick;
    ce && controlTick;
  endsequence

  sequence sSetup;
    ce && psel && !penable;
  endsequence

  a_running_level: assert property ( // R1
    sTick |=> runningOn_q == ($past(motorSpeed) > {2'h0, $past(rotLevel_q)}))
    else $error("running level does not follow speed comparison");

  a_level_range: assert property ( // R2
    rotLevel_q >= ROT_LEVEL_MIN && rotLevel_q <= ROT_LEVEL_MAX &&
    nearWidth_q >= NEAR_WIDTH_MIN && nearWidth_q <= NEAR_WIDTH_MAX)
    else $error("setting outside its range");

  a_display_tracks: assert property ( // R3
    ce && runningOn_q |=> statusDisplayRun && speedMonitorRun)
    else $error("display does not show running");

  a_ready_alarm: assert property ( // R5
    ce && (alarmActive || !mainPowerOn) |=> !readyOn_q ##1 (!ce || readyOn_q || !circuitOn[2]
      || outSel1_q[SEL1_READY_LSB +: ROUTE_W] != 4'h3 || circuitOutN[2]))
    else $error("ready asserted during alarm or power off");

  a_ready_abs: assert property ( // R6
    ce && absEncoderFitted && !(absReqSync && absDataSent) |=> !readyOn_q)
    else $error("ready without absolute data");

  a_warn_level: assert property ( // R7
    ce |=> warnOn_q == ($past(overloadWarn) || $past(regenWarn)))
    else $error("warning level wrong");

  a_running_route: assert property ( // R9
    ce && runningOn_q && outSel1_q[SEL1_RUNNING_LSB +: ROUTE_W] == 4'h2 |=> !circuitOutN[1])
    else $error("routed running not on circuit two");

  a_code_alarm: assert property ( // R10
    ce && alarmActive |=> {codeBitThirdN, codeBitSecondN, codeBitFirstN} == ~$past(alarmCode))
    else $error("alarm code not given priority");

  a_code_overload: assert property ( // R11
    ce && codeSel_q && !alarmActive && overloadWarn
      |=> {codeBitThirdN, codeBitSecondN, codeBitFirstN} == 3'h6)
    else $error("overload code wrong");

  a_near_mode: assert property ( // R12
    ce && controlTick && !posMode |=> !nearOn_q)
    else $error("near active outside position control");

  a_hold_between: assert property ( // R16
    ce && !controlTick |=> $stable(runningOn_q) && $stable(nearOn_q))
    else $error("comparison changed between control ticks");

  a_apb_answer: assert property (
    sSetup ##1 ce |-> pready ##1 (!pready || !ce))
    else $error("bus answer not one cycle after setup");

endmodule
`default_nettype wire

//--- design/svo_sync.sv
`timescale 1ns/1ps
`default_nettype none
module svo_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  // Asynchronous input and its synchronised copy.
  input  wire logic [W-1:0] asyncIn,
  output var  logic [W-1:0] syncOut
);

  logic [W-1:0] stage1_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stage1_q <= '0;
      syncOut  <= '0;
    end else if (ce) begin
      stage1_q <= asyncIn;
      syncOut  <= stage1_q;
    end
  end

endmodule
`default_nettype wire

//--- pkg/svo_pkg.sv
`default_nettype none
package svo_pkg;

  // Control mode of the amplifier, supplied by the control core.
  typedef enum logic [1:0] {
    MODE_SPEED    = 2'b00,
    MODE_POSITION = 2'b01,
    MODE_TORQUE   = 2'b10
  } svo_mode_t;

  localparam int NUM_CIRCUITS = 3;
  localparam int NUM_ROUTED   = 5;
  localparam int ROUTE_W      = 4;

  // Register byte addresses.
  localparam logic [7:0] ADDR_ROT_LEVEL  = 8'h00;
  localparam logic [7:0] ADDR_OUT_SEL1   = 8'h04;
  localparam logic [7:0] ADDR_OUT_SEL2   = 8'h08;
  localparam logic [7:0] ADDR_OUT_SEL3   = 8'h0c;
  localparam logic [7:0] ADDR_NEAR_WIDTH = 8'h10;
  localparam logic [7:0] ADDR_CODE_SEL   = 8'h14;
  localparam logic [7:0] ADDR_STATUS     = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STAT   = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h20;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h24;

  // Reset values and accepted ranges of the settings.
  localparam logic [13:0] ROT_LEVEL_RST  = 14'h0014;
  localparam logic [13:0] ROT_LEVEL_MIN  = 14'h0001;
  localparam logic [13:0] ROT_LEVEL_MAX  = 14'h2710;
  localparam logic [15:0] OUT_SEL1_RST   = 16'h3211;
  localparam logic [15:0] OUT_SEL2_RST   = 16'h0000;
  localparam logic [15:0] OUT_SEL3_RST   = 16'h0000;
  localparam logic [7:0]  NEAR_WIDTH_RST = 8'h07;
  localparam logic [7:0]  NEAR_WIDTH_MIN = 8'h01;
  localparam logic [7:0]  NEAR_WIDTH_MAX = 8'hfa;
  localparam logic        CODE_SEL_RST   = 1'b0;

  // Routing field positions.
  localparam int SEL1_POSDONE_LSB = 0;
  localparam int SEL1_SPDMATCH_LSB = 4;
  localparam int SEL1_RUNNING_LSB = 8;
  localparam int SEL1_READY_LSB   = 12;
  localparam int SEL2_WARN_LSB    = 12;
  localparam int SEL3_NEAR_LSB    = 0;

  // Status and interrupt bit positions.
  localparam int ST_RUNNING = 0;
  localparam int ST_READY   = 1;
  localparam int ST_WARN    = 2;
  localparam int ST_NEAR    = 3;
  localparam int ST_CIRC    = 4;
  localparam int IRQ_W      = 4;

  // True when a routing field selects the given output circuit (1 to 3).
  function automatic logic routeHit(input logic [3:0] field, input int circuit);
    routeHit = (field == 4'(circuit));
  endfunction

endpackage
`default_nettype wire
